// ==== rtl/drc_dram_row_config_regs.sv ====
`timescale 1ns/1ns
// What this block does
// RULE_01: Fast-page or EXTENDED_OUTPUT_DRAM row: map code 00 disables, others pick scheme.
// RULE_02: Synchronous row: all four map codes pick a scheme, none disables.
// RULE_03: Type field 5-4 selects fast-page, EXTENDED_OUTPUT_DRAM, registered SDRAM, SDRAM.
// RULE_04: First config byte holds top boundary address bits 27 to 20.
// RULE_05: Second byte bits 3-0 are boundary bits 31-28, joined with low.
// RULE_06: Density bit n set selects 256Mbit addressing for row n.
// RULE_07: Bank bit n set means four internal banks, clear means two.
// RULE_08: Access goes to first enabled row whose top exceeds the address.
module drc_dram_row_config_regs
  import drc_pkg::*;
(
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Memory access lookup
  input wire logic mem_req_valid,
  input wire logic [31:0] mem_req_addr,
  output logic route_valid,
  output drc_pkg::drc_route_t route
);
  import drc_pkg::*;

  // ==========================================================
  // Register storage
  drc_row_cfg_t row_cfg [DRC_ROWS];
  drc_row_cfg_t next_row_cfg [DRC_ROWS];
  logic [7:0] row_high_density_select;
  logic [7:0] next_row_high_density_select;
  logic [7:0] row_bank_count_select;
  logic [7:0] next_row_bank_count_select;
  logic [31:0] next_prdata;
  drc_row_info_t info [DRC_ROWS];

  logic [7:0] idx;
  logic aligned;
  logic is_row;
  logic mapped;
  logic [2:0] row_sel;
  logic wr_en;
  logic sel_row;
  logic sel_density;
  logic sel_banks;
  logic xfer_done;
  logic rd_loaded;
  logic next_rd_loaded;

  assign idx = paddr[DRC_IDX_MSB:DRC_IDX_LSB];
  assign aligned = (paddr[1:0] == DRC_BYTE_OFS) &&
                   (paddr[31:DRC_IDX_MSB+1] == '0);
  assign is_row = (idx >= DRC_IDX_ROW_BASE) && (idx <= DRC_IDX_ROW_LAST);
  assign row_sel = idx[3:1];

  // ==========================================================
  // Address decode
  always_comb begin
    mapped = 1'b0;
    sel_row = 1'b0;
    sel_density = 1'b0;
    sel_banks = 1'b0;
    if (!aligned) begin
      mapped = 1'b0;
    end else if (is_row) begin
      mapped = 1'b1;
      sel_row = 1'b1;
    end else if (idx == DRC_IDX_ROW_HIGH_DENSITY_SELECT) begin
      mapped = 1'b1;
      sel_density = 1'b1;
    end else if (idx == DRC_IDX_ROW_BANK_COUNT_SELECT) begin
      mapped = 1'b1;
      sel_banks = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end

  // ==========================================================
  // Bus handshake
  // Ready waits for read data loaded at an enabled edge: a setup
  // edge lost to a low enable costs one wait state, not stale data
  assign pready = pclk_en && rd_loaded;
  assign pslverr = psel && penable && !mapped;
  assign xfer_done = psel && penable && pready;
  assign wr_en = xfer_done && pwrite && mapped && pstrb[0];

  always_comb begin
    next_rd_loaded = psel && !xfer_done;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_loaded <= 1'b0;
    end else if (pclk_en) begin
      rd_loaded <= next_rd_loaded;
    end
  end

  // ==========================================================
  // Register writes
  always_comb begin
    next_row_cfg = row_cfg;
    next_row_high_density_select = row_high_density_select;
    next_row_bank_count_select = row_bank_count_select;
    if (wr_en) begin
      if (sel_row) begin
        if (idx[0]) begin
          next_row_cfg[row_sel].type_map_boundary_high = pwdata[7:0];
        end else begin
          next_row_cfg[row_sel].top_boundary_low = pwdata[7:0];
        end
      end else if (sel_density) begin
        next_row_high_density_select = pwdata[7:0];
      end else if (sel_banks) begin
        next_row_bank_count_select = pwdata[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < DRC_ROWS; i++) begin
        row_cfg[i] <= {DRC_REG_RESET, DRC_REG_RESET};
      end
      row_high_density_select <= DRC_REG_RESET;
      row_bank_count_select <= DRC_REG_RESET;
    end else if (pclk_en) begin
      row_cfg <= next_row_cfg;
      row_high_density_select <= next_row_high_density_select;
      row_bank_count_select <= next_row_bank_count_select;
    end
  end

  // ==========================================================
  // Read data
  // Reloads at every enabled edge of a selected cycle, so it
  // leaves a flop and is still right after a frozen setup edge
  always_comb begin
    next_prdata = prdata;
    if (psel) begin
      next_prdata = '0;
      if (!mapped || pwrite) begin
        next_prdata = '0;
      end else if (sel_row) begin
        if (idx[0]) begin
          next_prdata[7:0] = row_cfg[row_sel].type_map_boundary_high;
        end else begin
          next_prdata[7:0] = row_cfg[row_sel].top_boundary_low;
        end
      end else if (sel_density) begin
        next_prdata[7:0] = row_high_density_select;
      end else begin
        next_prdata[7:0] = row_bank_count_select;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (pclk_en) begin
      prdata <= next_prdata;
    end
  end

  // ==========================================================
  // Per-row decode
  for (genvar g = 0; g < DRC_ROWS; g++) begin : g_row
    drc_row_decode u_dec (
      .cfg(row_cfg[g]),
      .info(info[g])
    );
  end

  // ==========================================================
  // Row routing; lowest row wins, so rows must be programmed
  // with rising tops or a lower row shadows a higher one
  drc_route_t next_route;
  logic next_route_valid;
  logic [DRC_BOUND_W-1:0] req_top;

  assign req_top = mem_req_addr[DRC_ADDR_TOP_MSB:DRC_ADDR_TOP_LSB];

  always_comb begin
    next_route = '0;
    next_route_valid = mem_req_valid;
    for (int i = DRC_ROWS - 1; i >= 0; i--) begin
      if (info[i].enabled && (info[i].top > req_top)) begin // RULE_08
        next_route.hit = 1'b1;
        next_route.row = 3'(i);
        next_route.dram_type = info[i].dram_type; // RULE_03
        next_route.is_sync = info[i].is_sync;
        next_route.map_sel = info[i].map_sel; // RULE_01 RULE_02
        next_route.high_density = row_high_density_select[i]; // RULE_06
        next_route.four_banks = row_bank_count_select[i]; // RULE_07
      end
    end
    if (!mem_req_valid) begin
      next_route = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      route <= '0;
      route_valid <= 1'b0;
    end else if (pclk_en) begin
      route <= next_route;
      route_valid <= next_route_valid;
    end
  end
endmodule

// ==== rtl/drc_pkg.sv ====
package drc_pkg;
  // ==========================================================
  // Register map: word index, byte address is index times four
  localparam int DRC_ROWS = 8;
  localparam logic [7:0] DRC_IDX_ROW_BASE = 8'h60;
  localparam logic [7:0] DRC_IDX_ROW_LAST = 8'h6f;
  localparam logic [7:0] DRC_IDX_ROW6_TYPE_MAP_BOUNDARY_HIGH = 8'h6d;
  localparam logic [7:0] DRC_IDX_ROW7_TOP_BOUNDARY_LOW = 8'h6e;
  localparam logic [7:0] DRC_IDX_ROW7_TYPE_MAP_BOUNDARY_HIGH = 8'h6f;
  localparam logic [7:0] DRC_IDX_ROW_HIGH_DENSITY_SELECT = 8'h70;
  localparam logic [7:0] DRC_IDX_ROW_BANK_COUNT_SELECT = 8'h71;
  localparam logic [7:0] DRC_REG_RESET = 8'h00;
  localparam logic [1:0] DRC_BYTE_OFS = 2'h0;
  localparam int DRC_IDX_LSB = 2;
  localparam int DRC_IDX_MSB = 9;

  // ==========================================================
  // Field positions in the second configuration byte
  localparam int DRC_MAP_MSB = 7;
  localparam int DRC_MAP_LSB = 6;
  localparam int DRC_TYPE_MSB = 5;
  localparam int DRC_TYPE_LSB = 4;
  localparam int DRC_BOUND_HI_MSB = 3;
  localparam int DRC_BOUND_W = 12;
  localparam int DRC_ADDR_TOP_MSB = 31;
  localparam int DRC_ADDR_TOP_LSB = 20;
  localparam logic [1:0] DRC_MAP_DISABLED = 2'h0;

  typedef enum logic [1:0] {
    DRC_FAST_PAGE_DRAM = 2'h0,
    DRC_EXTENDED_OUTPUT_DRAM = 2'h1,
    DRC_REGISTERED_SDRAM = 2'h2,
    DRC_SDRAM = 2'h3
  } drc_dram_type_t;

  // Both configuration bytes of one row
  typedef struct packed {
    logic [7:0] type_map_boundary_high;
    logic [7:0] top_boundary_low;
  } drc_row_cfg_t;

  // Decoded view of one row
  typedef struct packed {
    logic enabled;
    logic is_sync;
    drc_dram_type_t dram_type;
    logic [1:0] map_sel;
    logic [DRC_BOUND_W-1:0] top;
  } drc_row_info_t;

  // Routing answer for one memory access
  typedef struct packed {
    logic hit;
    logic [2:0] row;
    drc_dram_type_t dram_type;
    logic is_sync;
    logic [1:0] map_sel;
    logic high_density;
    logic four_banks;
  } drc_route_t;
endpackage

// ==== rtl/drc_row_decode.sv ====
`timescale 1ns/1ns
module drc_row_decode
  import drc_pkg::*;
(
  // Raw configuration
  input drc_pkg::drc_row_cfg_t cfg,
  // Decoded row
  output drc_pkg::drc_row_info_t info
);
  logic [1:0] map_code;
  logic [1:0] type_code;

  assign map_code = cfg.type_map_boundary_high[DRC_MAP_MSB:DRC_MAP_LSB];
  assign type_code = cfg.type_map_boundary_high[DRC_TYPE_MSB:DRC_TYPE_LSB];

  always_comb begin
    info.dram_type = drc_dram_type_t'(type_code); // RULE_03
    info.is_sync = (type_code == DRC_REGISTERED_SDRAM) ||
                   (type_code == DRC_SDRAM); // RULE_03
    info.map_sel = map_code;
    // Asynchronous rows lose code zero to the disable meaning
    if (info.is_sync) begin
      info.enabled = 1'b1; // RULE_02
    end else begin
      info.enabled = (map_code != DRC_MAP_DISABLED); // RULE_01
    end
    // High nibble joins the low byte to form A31..A20 of the top
    info.top = {cfg.type_map_boundary_high[DRC_BOUND_HI_MSB:0],
                cfg.top_boundary_low}; // RULE_04 RULE_05
  end
endmodule

// ==== test/drc_assertions.sv ====
`timescale 1ns/1ns
module drc_assertions
  import drc_pkg::*;
(
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclk_en,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // Lookup
  input wire logic mem_req_valid,
  input wire logic route_valid,
  input drc_pkg::drc_route_t route
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_map_off_miss: assert property (route.hit && !route.is_sync |->
    route.map_sel != DRC_MAP_DISABLED) else $error("disabled row hit");
  a_sync_by_type: assert property (route.hit |->
    route.is_sync == route.dram_type[1]) else $error("sync flag wrong");
  a_idle_zero: assert property (!route_valid |-> route == '0)
    else $error("route not idle");
  a_valid_lag: assert property (pclk_en |=>
    route_valid == $past(mem_req_valid)) else $error("route valid late");
  a_freeze_route: assert property (!pclk_en |=> $stable(route))
    else $error("route moved while frozen");
  // Registers are one byte wide, so upper read bytes never carry data
  a_upper_zero: assert property (prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_err_in_access: assert property (pslverr |-> psel && penable)
    else $error("error outside access");
  a_err_misalign: assert property (psel && penable && paddr[1:0] != 2'h0
    |-> pslverr) else $error("misaligned access accepted");
endmodule
bind drc_dram_row_config_regs drc_assertions i_chk (
  .pclk(pclk),
  .presetn(presetn),
  .pclk_en(pclk_en),
  .psel(psel),
  .penable(penable),
  .paddr(paddr),
  .prdata(prdata),
  .pslverr(pslverr),
  .mem_req_valid(mem_req_valid),
  .route_valid(route_valid),
  .route(route)
);

// ==== test/drc_mem_rows.sv ====
`timescale 1ns/1ns
module drc_mem_rows
  import drc_pkg::*;
(
  // Routing from the controller
  input wire logic route_valid,
  input drc_pkg::drc_route_t route,
  // One select per memory row
  output logic [7:0] row_sel
);
  // A miss leaves every row idle instead of falling back to row 0
  assign row_sel = (route_valid && route.hit) ?
                   8'h01 << route.row : 8'h00;
endmodule

// ==== test/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
  import drc_pkg::*;
  logic pclk = 0, presetn = 0, pclk_en = 1, psel = 0, penable = 0;
  logic pwrite = 0, mem_req_valid = 0, pready, pslverr, route_valid, ok;
  logic [31:0] paddr = 0, pwdata = 0, mem_req_addr = 0, prdata, w;
  logic [3:0] pstrb = 0;
  logic [7:0] row_sel, hi, regs [96:113];
  logic [11:0] t;
  drc_route_t route, exp;
  int miscompares = 0, num_checks = 0;
  always #10 pclk = ~pclk;
  drc_dram_row_config_regs i_dut (
    .pclk(pclk),
    .presetn(presetn),
    .pclk_en(pclk_en),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .mem_req_valid(mem_req_valid),
    .mem_req_addr(mem_req_addr),
    .route_valid(route_valid),
    .route(route)
  );
  drc_mem_rows i_rows (
    .route_valid(route_valid),
    .route(route),
    .row_sel(row_sel)
  );
  task automatic check(input logic [31:0] got, input logic [31:0] want);
    num_checks++;
    if (got !== want) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ==========
  // APB master; random strobes hit the write refusal path and enable stalls add wait states
  task automatic apb(input logic wr, input logic [31:0] a);
    ok = a[1:0] == 0 && a[31:10] == 0 && a[9:2] >= 96 && a[9:2] <= 113;
    w = $urandom;
    @(posedge pclk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= w;
    pstrb <= w[11:8];
    pclk_en <= w[12];
    @(posedge pclk);
    penable <= 1;
    pclk_en <= w[13];
    // Response is taken at the edge that samples ready high
    do begin
      @(posedge pclk);
      pclk_en <= 1;
    end while (pready !== 1'b1);
    check(pslverr, !ok);
    if (!wr) check(prdata, ok ? {24'h0, regs[a[9:2]]} : 0);
    if (wr && ok && w[8]) regs[a[9:2]] = w[7:0];
    psel <= 0;
    penable <= 0;
  endtask
  // ==========
  // Lookup; rows are scanned downward so the lowest hit wins
  task automatic lookup(input logic [31:0] a);
    exp = '0;
    for (int r = 7; r >= 0; r--) begin
      hi = regs[97 + 2 * r];
      t = {hi[3:0], regs[96 + 2 * r]};
      if ((hi[5] || hi[7:6] != 2'h0) && t > a[31:20])
        exp = {1'b1, 3'(r), hi[5:4], hi[5], hi[7:6], regs[112][r],
          regs[113][r]};
    end
    @(posedge pclk);
    mem_req_valid <= 1;
    mem_req_addr <= a;
    @(posedge pclk);
    mem_req_valid <= 0;
    #1;
    check(route, exp);
    check(row_sel, {31'h0, exp.hit} << exp.row);
  endtask
  initial begin
    void'($urandom(15));
    foreach (regs[i]) regs[i] = 8'h00;
    repeat (8) @(posedge pclk);
    presetn <= 1;
    for (int i = 96; i <= 114; i++) apb(0, i << 2);
    repeat (800) begin
      w = $urandom;
      t = {regs[97 + 2 * w[2:0]][3:0], regs[96 + 2 * w[2:0]]};
      if (w[31]) apb(w[30], 32'(96 + w[27:23] % 19) << 2
        | 32'(w[22:20] == 0));
      else lookup(w[3] ? {t - 12'(w[4]), w[19:0]} : $urandom);
    end
    // Mid-run reset must clear every register again
    @(posedge pclk);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    foreach (regs[i]) regs[i] = 8'h00;
    for (int i = 96; i <= 113; i++) apb(0, i << 2);
    lookup($urandom);
    finish_test;
  end
  initial begin
    #400_000 miscompares++;
    finish_test;
  end
endmodule
